// >>> program_memory_table_read.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - 8K x 16 program store, fetched by address
// - reset restarts fetching at address zero
// - table data addressed by table pointer
// - table address joins low and high pointer, last-page forms use the last page for the high part
// - low byte goes to operand data location
// - high byte loads table high-byte latch
// - unimplemented high-byte bits read as zero
// - basic forms sector 0, extended other sectors
// - table instructions take two cycles
// - high-byte latch readable and writable by software
// - serial programming over shared data, clock lines
// - debug data bidirectional, debug clock input
// - debugging disables shared functions, programming stays
module program_memory_table_read #(
	parameter int ADDR_W = program_memory_table_read_pkg::ADDR_W,
	parameter int WORD_W = program_memory_table_read_pkg::WORD_W,
	parameter int MEM_DEPTH = program_memory_table_read_pkg::MEM_DEPTH
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic pc_load,
	input wire logic [12:0] pc_value,
	input wire logic pc_advance,
	output logic [12:0] fetch_addr,
	output logic [15:0] instr_word,
	input wire logic reg_wdata_valid,
	input wire logic ptr_lo_wr,
	input wire logic ptr_hi_wr,
	input wire logic latch_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] ptr_lo,
	output logic [7:0] ptr_hi,
	output logic [7:0] table_high_byte_latch,
	input wire logic table_req,
	input wire program_memory_table_read_pkg::table_op_t table_op,
	input wire logic [9:0] table_dest,
	output logic table_busy,
	output logic dm_wr,
	output logic [9:0] dm_addr,
	output logic [7:0] dm_wdata,
	input wire logic prog_enable,
	input wire logic debug_active,
	input wire logic prog_serial_clock_pin,
	input wire logic prog_serial_data_pin_in,
	output logic prog_serial_data_pin_out,
	output logic prog_serial_data_pin_oe,
	input wire logic alt_data_out,
	input wire logic alt_data_oe,
	output logic alt_data_in
);

	// program store, two-state so unwritten words read as zero, never unknown
	bit [WORD_W-1:0] mem [MEM_DEPTH];

	// keeps unused high-byte bits at zero
	function automatic logic [7:0] high_byte(input logic [WORD_W-1:0] w);
		logic [15:0] wide;
		wide = 16'h0000;
		wide[WORD_W-1:0] = w;
		return wide[15:8];
	endfunction

	// pin synchronisers
	logic [1:0] sclk_sync, sdat_sync, pen_sync, dbg_sync;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_sync <= 2'h0;
			sdat_sync <= 2'h0;
			pen_sync <= 2'h0;
			dbg_sync <= 2'h0;
		end
		else
		begin
			sclk_sync <= {sclk_sync[0], prog_serial_clock_pin};
			sdat_sync <= {sdat_sync[0], prog_serial_data_pin_in};
			pen_sync <= {pen_sync[0], prog_enable};
			dbg_sync <= {dbg_sync[0], debug_active};
		end
	end

	logic sclk_q, ser_on, sclk_rise;
	assign ser_on = pen_sync[1] | dbg_sync[1];
	assign sclk_rise = sclk_sync[1] & ~sclk_q;

	// instruction fetch path
	logic [12:0] next_fetch_addr;
	always_comb
	begin
		next_fetch_addr = fetch_addr;
		if (pc_load)
			next_fetch_addr = pc_value;
		else if (pc_advance)
			next_fetch_addr = fetch_addr + 13'h0001;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fetch_addr <= program_memory_table_read_pkg::RESET_VECTOR;
			instr_word <= 16'h0000;
			sclk_q <= 1'b0;
		end
		else
		begin
			fetch_addr <= next_fetch_addr;
			instr_word <= mem[fetch_addr];
			sclk_q <= sclk_sync[1];
		end
	end

	// table read engine
	program_memory_table_read_pkg::table_state_t tstate, next_tstate;
	program_memory_table_read_pkg::table_op_t op_q, next_op_q;
	logic [9:0] dest_q, next_dest_q, next_dm_addr;
	logic [7:0] next_ptr_lo, next_ptr_hi, next_latch, next_dm_wdata;
	logic next_dm_wr;
	logic [12:0] table_addr;
	logic [WORD_W-1:0] rd_word;

	// pointer ignores high bits above the store size
	always_comb
	begin
		if (op_q == program_memory_table_read_pkg::table_read_lastpage_op
			|| op_q == program_memory_table_read_pkg::ext_table_read_lastpage_op)
			table_addr = {program_memory_table_read_pkg::LAST_PAGE, ptr_lo};
		else
			table_addr = {ptr_hi[4:0], ptr_lo};
	end
	assign rd_word = mem[table_addr];

	always_comb
	begin
		next_tstate = tstate;
		next_op_q = op_q;
		next_dest_q = dest_q;
		next_ptr_lo = ptr_lo;
		next_ptr_hi = ptr_hi;
		next_latch = table_high_byte_latch;
		next_dm_wr = 1'b0;
		next_dm_addr = dm_addr;
		next_dm_wdata = dm_wdata;
		if (reg_wdata_valid && ptr_lo_wr)
			next_ptr_lo = reg_wdata;
		if (reg_wdata_valid && ptr_hi_wr)
			next_ptr_hi = reg_wdata;
		if (reg_wdata_valid && latch_wr)
			next_latch = reg_wdata;
		case (tstate)
			program_memory_table_read_pkg::st_idle:
			begin
				if (table_req)
				begin
					next_op_q = table_op;
					next_dest_q = table_dest;
					next_tstate = program_memory_table_read_pkg::st_read;
				end
			end
			program_memory_table_read_pkg::st_read:
			begin
				// basic forms reach sector 0 only
				if (!op_q[1])
					next_dm_addr = {program_memory_table_read_pkg::SECTOR_ZERO, dest_q[7:0]};
				else
					next_dm_addr = dest_q;
				next_dm_wdata = rd_word[7:0];
				next_latch = high_byte(rd_word);
				next_dm_wr = 1'b1;
				next_tstate = program_memory_table_read_pkg::st_write;
			end
			program_memory_table_read_pkg::st_write:
				next_tstate = program_memory_table_read_pkg::st_idle;
			default:
				next_tstate = program_memory_table_read_pkg::st_idle;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tstate <= program_memory_table_read_pkg::st_idle;
			op_q <= program_memory_table_read_pkg::table_read_op;
			dest_q <= 10'h000;
			ptr_lo <= program_memory_table_read_pkg::PTR_LO_RESET;
			ptr_hi <= program_memory_table_read_pkg::PTR_HI_RESET;
			table_high_byte_latch <= program_memory_table_read_pkg::LATCH_RESET;
			dm_wr <= 1'b0;
			dm_addr <= 10'h000;
			dm_wdata <= 8'h00;
		end
		else
		begin
			tstate <= next_tstate;
			op_q <= next_op_q;
			dest_q <= next_dest_q;
			ptr_lo <= next_ptr_lo;
			ptr_hi <= next_ptr_hi;
			table_high_byte_latch <= next_latch;
			dm_wr <= next_dm_wr;
			dm_addr <= next_dm_addr;
			dm_wdata <= next_dm_wdata;
		end
	end

	assign table_busy = (tstate != program_memory_table_read_pkg::st_idle);

	// serial programming engine
	program_memory_table_read_pkg::ser_state_t sstate, next_sstate;
	logic [4:0] bit_cnt, next_bit_cnt;
	logic [15:0] shreg, next_shreg;
	logic [12:0] ser_addr_q, next_ser_addr_q;
	logic ser_rd, next_ser_rd, mem_we;
	logic [15:0] ser_word;
	assign ser_word = 16'(mem[ser_addr_q]);

	always_comb
	begin
		next_sstate = sstate;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_ser_addr_q = ser_addr_q;
		next_ser_rd = ser_rd;
		mem_we = 1'b0;
		if (!ser_on)
			next_sstate = program_memory_table_read_pkg::ser_idle;
		else if (sclk_rise)
		begin
			case (sstate)
				program_memory_table_read_pkg::ser_idle:
				begin
					next_ser_rd = sdat_sync[1];
					next_bit_cnt = 5'h00;
					next_sstate = program_memory_table_read_pkg::ser_addr;
				end
				program_memory_table_read_pkg::ser_addr:
				begin
					next_ser_addr_q = {ser_addr_q[11:0], sdat_sync[1]};
					next_bit_cnt = bit_cnt + 5'h01;
					if (bit_cnt == program_memory_table_read_pkg::SER_ADDR_LAST)
					begin
						next_bit_cnt = 5'h00;
						next_sstate = ser_rd ? program_memory_table_read_pkg::ser_rdata
							: program_memory_table_read_pkg::ser_wdata;
					end
				end
				program_memory_table_read_pkg::ser_wdata:
				begin
					next_shreg = {shreg[14:0], sdat_sync[1]};
					next_bit_cnt = bit_cnt + 5'h01;
					if (bit_cnt == program_memory_table_read_pkg::SER_DATA_LAST)
					begin
						mem_we = 1'b1;
						next_sstate = program_memory_table_read_pkg::ser_idle;
					end
				end
				program_memory_table_read_pkg::ser_rdata:
				begin
					// first rise loads the word, later rises shift it out
					next_shreg = (bit_cnt == 5'h00) ? ser_word : {shreg[14:0], 1'b0};
					next_bit_cnt = bit_cnt + 5'h01;
					if (bit_cnt == 5'h10)
						next_sstate = program_memory_table_read_pkg::ser_idle;
				end
				default:
					next_sstate = program_memory_table_read_pkg::ser_idle;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sstate <= program_memory_table_read_pkg::ser_idle;
			bit_cnt <= 5'h00;
			shreg <= 16'h0000;
			ser_addr_q <= 13'h0000;
			ser_rd <= 1'b0;
		end
		else
		begin
			sstate <= next_sstate;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			ser_addr_q <= next_ser_addr_q;
			ser_rd <= next_ser_rd;
		end
	end

	// program store write port
	always_ff @(posedge mclk)
	begin
		if (mem_we)
			mem[ser_addr_q] <= WORD_W'({shreg[14:0], sdat_sync[1]});
	end

	// shared pin: serial engine owns it while programming or debugging
	logic ser_drive;
	assign ser_drive = (sstate == program_memory_table_read_pkg::ser_rdata) && (bit_cnt != 5'h00);
	assign prog_serial_data_pin_out = ser_on ? shreg[15] : alt_data_out;
	assign prog_serial_data_pin_oe = ser_on ? ser_drive : alt_data_oe;
	assign alt_data_in = dbg_sync[1] ? 1'b0 : sdat_sync[1];

	// checks
	logic after_reset;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			after_reset <= 1'b0;
		else
			after_reset <= 1'b1;
	end

	a_reset_vector: assert property (@(posedge mclk) disable iff (!arst_n)
		!after_reset |-> fetch_addr == 13'h0000)
		else $error("fetch did not start at address zero");
	a_fetch_word: assert property (@(posedge mclk) disable iff (!arst_n)
		after_reset |=> instr_word == 16'($past(mem[fetch_addr])))
		else $error("instruction word does not match store");
	a_two_cycles: assert property (@(posedge mclk) disable iff (!arst_n)
		(tstate == program_memory_table_read_pkg::st_idle && table_req)
		|=> table_busy ##1 (dm_wr && table_busy) ##1 !table_busy)
		else $error("table read did not take two cycles");
	a_ptr_address: assert property (@(posedge mclk) disable iff (!arst_n)
		(tstate == program_memory_table_read_pkg::st_read && !op_q[0])
		|-> table_addr == {ptr_hi[4:0], ptr_lo})
		else $error("table address not formed from pointer");
	a_low_byte: assert property (@(posedge mclk) disable iff (!arst_n)
		tstate == program_memory_table_read_pkg::st_read |=> dm_wdata == $past(rd_word[7:0]))
		else $error("low byte not delivered");
	a_high_latch: assert property (@(posedge mclk) disable iff (!arst_n)
		tstate == program_memory_table_read_pkg::st_read
		|=> table_high_byte_latch == high_byte($past(rd_word)))
		else $error("high byte latch not loaded");
	a_sector_zero: assert property (@(posedge mclk) disable iff (!arst_n)
		(dm_wr && !op_q[1]) |-> dm_addr[9:8] == 2'h0)
		else $error("basic form left sector zero");
	a_latch_write: assert property (@(posedge mclk) disable iff (!arst_n)
		(reg_wdata_valid && latch_wr && tstate != program_memory_table_read_pkg::st_read)
		|=> table_high_byte_latch == $past(reg_wdata))
		else $error("software write to latch lost");
	a_debug_pins: assert property (@(posedge mclk) disable iff (!arst_n)
		dbg_sync[1] |-> (!alt_data_in && prog_serial_data_pin_oe == ser_drive))
		else $error("shared function active during debug");

endmodule

`default_nettype wire

// >>> program_memory_table_read_pkg.sv
`default_nettype none
package program_memory_table_read_pkg;

	// program store geometry
	localparam int ADDR_W = 13;
	localparam int WORD_W = 16;
	localparam int MEM_DEPTH = 8192;
	localparam logic [12:0] RESET_VECTOR = 13'h0000;

	// table pointer layout
	localparam int PTR_HI_USED = 5;
	localparam logic [4:0] LAST_PAGE = 5'h1F;
	localparam logic [7:0] PTR_LO_RESET = 8'h00;
	localparam logic [7:0] PTR_HI_RESET = 8'h00;
	localparam logic [7:0] LATCH_RESET = 8'h00;

	// data-memory destination layout
	localparam int SECTOR_W = 2;
	localparam int DM_OFF_W = 8;
	localparam logic [1:0] SECTOR_ZERO = 2'h0;

	// table read length in instruction cycles
	localparam int TABLE_CYCLES = 2;

	// serial frame lengths
	localparam logic [4:0] SER_ADDR_LAST = 5'h0C;
	localparam logic [4:0] SER_DATA_LAST = 5'h0F;

	typedef enum logic [1:0] {
		table_read_op = 2'h0,
		table_read_lastpage_op = 2'h1,
		ext_table_read_op = 2'h2,
		ext_table_read_lastpage_op = 2'h3
	} table_op_t;

	typedef enum logic [2:0] {
		st_idle = 3'h1,
		st_read = 3'h2,
		st_write = 3'h4
	} table_state_t;

	typedef enum logic [3:0] {
		ser_idle = 4'h1,
		ser_addr = 4'h2,
		ser_wdata = 4'h4,
		ser_rdata = 4'h8
	} ser_state_t;

endpackage
`default_nettype wire

// >>> core_model.sv
`timescale 1ns/1ps
`default_nettype none
// processor core side issuing table reads
module core_model (
	input wire logic mclk,
	input wire logic dm_wr,
	output logic table_req,
	output program_memory_table_read_pkg::table_op_t table_op,
	output logic [9:0] table_dest
);
	initial
	begin
		table_req = 1'b0;
		table_op = program_memory_table_read_pkg::table_read_op;
		table_dest = 10'h000;
	end

	// one request edge, then count edges up to the write pulse
	task automatic read(input program_memory_table_read_pkg::table_op_t op,
		input logic [9:0] dest, output int lat);
		@(posedge mclk);
		table_req <= 1'b1;
		table_op <= op;
		table_dest <= dest;
		@(posedge mclk);
		table_req <= 1'b0;
		table_dest <= ~dest; // released operand shows no stale value
		lat = 1; // the taking edge opens the first instruction cycle
		do
		begin
			@(posedge mclk);
			#1;
			lat++;
		end
		while (dm_wr !== 1'b1 && lat < 8);
	endtask
endmodule
`default_nettype wire

// >>> program_memory_table_read_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module program_memory_table_read_tb_top;
	typedef struct packed {
		logic [1:0] op;
		logic [7:0] hi;
		logic [7:0] lo;
		logic [9:0] dest;
		logic [9:0] ea;
		logic [7:0] elo;
		logic [7:0] ehi;
	} row_t;
	localparam row_t rows [4] = '{
		'{2'h0, 8'hE1, 8'h23, 10'h345, 10'h045, 8'h5A, 8'hA5},
		'{2'h1, 8'h00, 8'h06, 10'h110, 10'h010, 8'h1A, 8'h3C},
		'{2'h2, 8'h01, 8'h23, 10'h277, 10'h277, 8'h5A, 8'hA5},
		'{2'h3, 8'h05, 8'h06, 10'h3FF, 10'h3FF, 8'h1A, 8'h3C}};
	logic [12:0] wa [3] = '{13'h1F06, 13'h0123, 13'h0000};
	logic [15:0] wd [3] = '{16'h3C1A, 16'hA55A, 16'h5EED};
	logic mclk, arst_n, pc_load, pc_advance, reg_wdata_valid, ptr_lo_wr, ptr_hi_wr, latch_wr;
	logic prog_enable, debug_active, sck, drv, dout, doe, alt_data_out, alt_data_oe, alt_data_in;
	logic table_req, table_busy, dm_wr;
	logic [12:0] pc_value, fetch_addr;
	logic [15:0] instr_word, q;
	logic [7:0] reg_wdata, ptr_lo, ptr_hi, table_high_byte_latch, dm_wdata;
	logic [9:0] table_dest, dm_addr;
	program_memory_table_read_pkg::table_op_t table_op;
	wire logic pin = doe ? dout : drv;
	int err_count = 0, samples_checked = 0, cycles = 0, lat;

	program_memory_table_read DUT (.mclk, .arst_n, .pc_load, .pc_value, .pc_advance,
		.fetch_addr, .instr_word, .reg_wdata_valid, .ptr_lo_wr, .ptr_hi_wr, .latch_wr,
		.reg_wdata, .ptr_lo, .ptr_hi, .table_high_byte_latch, .table_req, .table_op,
		.table_dest, .table_busy, .dm_wr, .dm_addr, .dm_wdata, .prog_enable, .debug_active,
		.prog_serial_clock_pin(sck), .prog_serial_data_pin_in(pin),
		.prog_serial_data_pin_out(dout), .prog_serial_data_pin_oe(doe),
		.alt_data_out, .alt_data_oe, .alt_data_in);
	core_model core (.mclk, .dm_wr, .table_req, .table_op, .table_dest);

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// hang guard
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			err_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// software register write, strobes {lo, hi, latch}
	task automatic wr(input logic [2:0] sel, input logic [7:0] d);
		@(posedge mclk);
		reg_wdata_valid <= 1'b1;
		{ptr_lo_wr, ptr_hi_wr, latch_wr} <= sel;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wdata_valid <= 1'b0;
		{ptr_lo_wr, ptr_hi_wr, latch_wr} <= 3'h0;
	endtask

	// serial frame: command, address, then data out or in, msb first
	task automatic ser(input logic rd, input logic [12:0] a, input logic [15:0] d);
		logic [29:0] bits;
		bits = {rd, a, d};
		for (int i = 0; i < (rd ? 31 : 30); i++)
		begin
			drv <= (i < 30) ? bits[29 - i] : 1'b0;
			repeat (4) @(posedge mclk);
			sck <= 1'b1;
			repeat (5) @(posedge mclk);
			if (rd && i > 13 && i < 30)
				q = {q[14:0], pin};
			if (rd && i == 20)
				chk("oe", 16'h0001, 16'(doe));
			sck <= 1'b0;
		end
	endtask

	initial
	begin
		{arst_n, pc_load, pc_advance, reg_wdata_valid, ptr_lo_wr, ptr_hi_wr, latch_wr} = 7'h00;
		{prog_enable, debug_active, sck, alt_data_out, alt_data_oe} = 5'h00;
		drv = 1'b1;
		pc_value = 13'h0000;
		reg_wdata = 8'h00;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("alt_in", 16'h0001, 16'(alt_data_in));
		debug_active <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("alt_in", 16'h0000, 16'(alt_data_in));
		// debug pins still program the store
		for (int i = 0; i < 3; i++)
			ser(1'b0, wa[i], wd[i]);
		debug_active <= 1'b0;
		prog_enable <= 1'b1;
		repeat (4) @(posedge mclk);
		ser(1'b1, 13'h1F06, 16'h0000);
		chk("ser_read", 16'h3C1A, q);
		chk("oe", 16'h0000, 16'(doe));
		prog_enable <= 1'b0;
		// serial engine off: shared function owns the pin again
		repeat (3) @(posedge mclk);
		alt_data_oe <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("alt_oe", 16'h0001, 16'(doe));
		chk("alt_in", 16'h0000, 16'(alt_data_in));
		alt_data_oe <= 1'b0;
		// each table read form
		for (int i = 0; i < 4; i++)
		begin
			wr(3'h4, rows[i].lo);
			wr(3'h2, rows[i].hi);
			core.read(program_memory_table_read_pkg::table_op_t'(rows[i].op), rows[i].dest, lat);
			chk("latency", 16'h0002, 16'(lat));
			chk("busy", 16'h0001, 16'(table_busy));
			chk("dm_addr", 16'(rows[i].ea), 16'(dm_addr));
			chk("dm_wdata", 16'(rows[i].elo), 16'(dm_wdata));
			chk("latch", 16'(rows[i].ehi), 16'(table_high_byte_latch));
		end
		chk("ptr_hi", 16'h0005, 16'(ptr_hi));
		chk("ptr_lo", 16'h0006, 16'(ptr_lo));
		wr(3'h1, 8'hC3);
		#1;
		chk("latch", 16'h00C3, 16'(table_high_byte_latch));
		// fetch path: load then advance
		@(posedge mclk);
		pc_load <= 1'b1;
		pc_value <= 13'h0123;
		@(posedge mclk);
		pc_load <= 1'b0;
		pc_advance <= 1'b1;
		@(posedge mclk);
		pc_advance <= 1'b0;
		#1;
		chk("fetch_addr", 16'h0124, 16'(fetch_addr));
		chk("instr_word", 16'hA55A, instr_word);
		// second reset mid-run
		@(posedge mclk);
		arst_n <= 1'b0;
		@(posedge mclk);
		#1;
		chk("fetch_addr", 16'h0000, 16'(fetch_addr));
		@(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		#1;
		chk("instr_word", 16'h5EED, instr_word);
		report_and_stop();
	end
endmodule
`default_nettype wire
